//--- scl_top.v
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
`include "scl_defines.vh"
// Behaviour
// - supply rise triggers reset and image load
// - overwrite allowed only when security clear
// - nonvolatile image of 444 bits
// - serial writes replace loaded defaults
// - integer, fractional or rational feedback mode
// - fractional divider 8-bit integer, 28-bit fraction; writes copy integer bits 3:0 into fraction bits 27:24
// - rational divider is numerator over denominator
// - two output dividers, range four to 259
// - output dividers offer divide by 4.5
// - loss-of-lock reported per loop
// - small frequency changes move smoothly; only the feedback word slews, the rational ratio jumps
// - loops independent, may share reference
// - reference copy output follows reference
module scl_top #(
  parameter WAIT_CYCLES = `SCL_CLK_HZ / 1000000 * `SCL_WAIT_US,
  parameter OTP_BITS = `SCL_OTP_BITS
)
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire supply_good,
  input wire [OTP_BITS-1:0] otp_image,
  input wire lock1_in,
  input wire lock2_in,
  input wire ref_in,
  output reg reference_copy_output,
  output wire pll1_enable,
  output wire pll2_enable,
  output wire ref_select,
  output wire [1:0] pll1_mode,
  output wire [1:0] pll2_mode,
  output wire [35:0] pll1_fb,
  output wire [35:0] pll2_fb,
  output wire [63:0] pll1_ratio,
  output wire [63:0] pll2_ratio,
  output wire [35:0] pll1_odiv,
  output wire [35:0] pll2_odiv,
  output wire irq
);
  localparam S_IDLE = 2'h0;
  localparam S_WAIT = 2'h1;
  localparam S_LOAD = 2'h2;
  localparam S_RUN = 2'h3;

  // synchronisers for pin inputs
  reg [1:0] sup_s;
  reg [1:0] l1_s;
  reg [1:0] l2_s;
  reg [1:0] ref_s;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sup_s <= 2'h0;
      l1_s <= 2'h0;
      l2_s <= 2'h0;
      ref_s <= 2'h0;
    end
    else
    begin
      sup_s <= {sup_s[0], supply_good};
      l1_s <= {l1_s[0], lock1_in};
      l2_s <= {l2_s[0], lock2_in};
      ref_s <= {ref_s[0], ref_in};
    end
  end
  wire sup = sup_s[1];
  wire lock1 = l1_s[1];
  wire lock2 = l2_s[1];

  reg [1:0] state;
  reg [31:0] wait_cnt;
  reg secure;
  reg [3:0] ctrl;
  reg [1:0] mode1;
  reg [1:0] mode2;
  reg [35:0] frac1;
  reg [35:0] frac2;
  reg [63:0] rat1;
  reg [63:0] rat2;
  reg [17:0] odiv1;
  reg [17:0] odiv2;
  reg [3:0] irq_stat;
  reg [3:0] irq_mask;
  reg lock1_d;
  reg lock2_d;
  reg load_d;

  // clamp a 9-bit divider code into 4..259, keeping the 4.5 code
  function [8:0] odiv_fix;
    input [8:0] c;
    begin
      if (c == `SCL_ODIV_HALF)
        odiv_fix = c;
      else if (c < `SCL_ODIV_MIN)
        odiv_fix = `SCL_ODIV_MIN;
      else if (c > `SCL_ODIV_MAX)
        odiv_fix = `SCL_ODIV_MAX;
      else
        odiv_fix = c;
    end
  endfunction

  function [1:0] mode_fix;
    input [1:0] m;
    begin
      mode_fix = (m == 2'h3) ? `SCL_MODE_INT : m;
    end
  endfunction

  wire loaded = (state == S_RUN);
  wire acc = psel && penable;
  wire wr = acc && pwrite && loaded;
  // with secure set, image-backed registers are frozen; status regs stay live
  wire cfg_ok = wr && !secure;
  // irq registers are not image-backed, so a secure part still clears them
  wire cfg_lo = (paddr == `SCL_ADDR_CTRL);
  wire cfg_hi = (paddr >= `SCL_ADDR_P1_MODE) && (paddr <= `SCL_ADDR_P2_ODIV);
  wire cfg_addr = cfg_lo || cfg_hi;
  wire denied = acc && pwrite && (!loaded || (secure && cfg_addr));
  wire mapped = (paddr <= `SCL_ADDR_P2_NOW) && (paddr[1:0] == 2'h0);
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

  wire [31:0] wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= S_IDLE;
      wait_cnt <= 32'h0;
    end
    else
    begin
      case (state)
        S_IDLE:
        begin
          wait_cnt <= 32'h0;
          if (sup)
            state <= S_WAIT;
        end
        S_WAIT:
        begin
          // a brown-out restarts the whole load
          if (!sup)
            state <= S_IDLE;
          else if (wait_cnt >= WAIT_CYCLES - 1)
            state <= S_LOAD;
          else
            wait_cnt <= wait_cnt + 32'h1;
        end
        S_LOAD:
          state <= S_RUN;
        S_RUN:
          if (!sup)
            state <= S_IDLE;
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // the image is copied in one cycle; its bit 0 is the security flag
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      secure <= 1'b0;
      ctrl <= 4'h0;
      mode1 <= 2'h0;
      mode2 <= 2'h0;
      frac1 <= 36'h0;
      frac2 <= 36'h0;
      rat1 <= 64'h0;
      rat2 <= 64'h0;
      odiv1 <= 18'h0;
      odiv2 <= 18'h0;
    end
    else if (state == S_LOAD)
    begin
      secure <= otp_image[0];
      ctrl <= otp_image[4:1];
      mode1 <= mode_fix(otp_image[6:5]);
      mode2 <= mode_fix(otp_image[8:7]);
      frac1 <= otp_image[44:9];
      frac2 <= otp_image[80:45];
      rat1 <= otp_image[144:81];
      rat2 <= otp_image[208:145];
      odiv1 <= {odiv_fix(otp_image[217:209]), odiv_fix(otp_image[226:218])};
      odiv2 <= {odiv_fix(otp_image[235:227]), odiv_fix(otp_image[244:236])};
    end
    else if (cfg_ok)
    begin
      case (paddr)
        `SCL_ADDR_CTRL:
          ctrl <= (ctrl & ~wmask[3:0]) | (pwdata[3:0] & wmask[3:0]);
        `SCL_ADDR_P1_MODE:
          if (pstrb[0])
            mode1 <= mode_fix(pwdata[1:0]);
        `SCL_ADDR_P2_MODE:
          if (pstrb[0])
            mode2 <= mode_fix(pwdata[1:0]);
        `SCL_ADDR_P1_FRAC:
          frac1 <= {pwdata[31:24], pwdata[27:0]};
        `SCL_ADDR_P2_FRAC:
          frac2 <= {pwdata[31:24], pwdata[27:0]};
        `SCL_ADDR_P1_RAT:
          rat1 <= {rat1[31:0], pwdata};
        `SCL_ADDR_P2_RAT:
          rat2 <= {rat2[31:0], pwdata};
        `SCL_ADDR_P1_ODIV:
          odiv1 <= {odiv_fix(pwdata[24:16]), odiv_fix(pwdata[8:0])};
        `SCL_ADDR_P2_ODIV:
          odiv2 <= {odiv_fix(pwdata[24:16]), odiv_fix(pwdata[8:0])};
        default:
          ctrl <= ctrl;
      endcase
    end
  end

  // fractional word stores 8-bit integer over 28-bit fraction; the shared
  // top byte means integer bits overlay fraction bits 27:24 are dropped
  wire [35:0] fb1_now;
  wire [35:0] fb2_now;
  wire busy1;
  wire busy2;
  // slew jumps a cycle after the copy, once frac already holds the image
  scl_slew #(.W(36)) u_slew1 (
    .pclk(pclk),
    .presetn(presetn),
    .load(load_d),
    .target(frac1),
    .now(fb1_now),
    .busy(busy1)
  );
  scl_slew #(.W(36)) u_slew2 (
    .pclk(pclk),
    .presetn(presetn),
    .load(load_d),
    .target(frac2),
    .now(fb2_now),
    .busy(busy2)
  );

  assign pll1_enable = ctrl[`SCL_CTRL_PLL1_EN];
  assign pll2_enable = ctrl[`SCL_CTRL_PLL2_EN];
  assign ref_select = ctrl[`SCL_CTRL_REF2];
  assign pll1_mode = mode1;
  assign pll2_mode = mode2;
  assign pll1_fb = fb1_now;
  assign pll2_fb = fb2_now;
  assign pll1_ratio = rat1;
  assign pll2_ratio = rat2;
  assign pll1_odiv = {odiv1[17:9], 9'h0, odiv1[8:0], 9'h0};
  assign pll2_odiv = {odiv2[17:9], 9'h0, odiv2[8:0], 9'h0};

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reference_copy_output <= 1'b0;
    else
      reference_copy_output <= ref_s[1] & ctrl[`SCL_CTRL_REFCOPY_EN];
  end

  // events: falling lock, load done, refused write; set beats clear
  wire [3:0] ev;
  assign ev[`SCL_IRQ_LOL1] = lock1_d & ~lock1 & loaded;
  assign ev[`SCL_IRQ_LOL2] = lock2_d & ~lock2 & loaded;
  assign ev[`SCL_IRQ_LOADED] = (state == S_LOAD);
  assign ev[`SCL_IRQ_DENIED] = denied;
  wire [3:0] w1c = (wr && paddr == `SCL_ADDR_IRQ_STAT && pstrb[0]) ? pwdata[3:0] : 4'h0;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lock1_d <= 1'b0;
      lock2_d <= 1'b0;
      load_d <= 1'b0;
      irq_stat <= 4'h0;
      irq_mask <= 4'h0;
    end
    else
    begin
      lock1_d <= lock1;
      lock2_d <= lock2;
      load_d <= (state == S_LOAD);
      irq_stat <= (irq_stat & ~w1c) | ev;
      if (wr && paddr == `SCL_ADDR_IRQ_MASK && pstrb[0])
        irq_mask <= pwdata[3:0];
    end
  end
  assign irq = |(irq_stat & irq_mask);

  reg [31:0] rd_word;
  always @*
  begin
    rd_word = 32'h0;
    case (paddr)
      `SCL_ADDR_CTRL: rd_word = {28'h0, ctrl};
      `SCL_ADDR_STATUS: rd_word = {26'h0, busy2, busy1, lock2, lock1, secure, loaded};
      `SCL_ADDR_IRQ_STAT: rd_word = {28'h0, irq_stat};
      `SCL_ADDR_IRQ_MASK: rd_word = {28'h0, irq_mask};
      `SCL_ADDR_P1_MODE: rd_word = {30'h0, mode1};
      `SCL_ADDR_P2_MODE: rd_word = {30'h0, mode2};
      `SCL_ADDR_P1_FRAC: rd_word = {frac1[35:28], frac1[23:0]};
      `SCL_ADDR_P2_FRAC: rd_word = {frac2[35:28], frac2[23:0]};
      `SCL_ADDR_P1_RAT: rd_word = rat1[31:0];
      `SCL_ADDR_P2_RAT: rd_word = rat2[31:0];
      `SCL_ADDR_P1_ODIV: rd_word = {7'h0, odiv1[17:9], 7'h0, odiv1[8:0]};
      `SCL_ADDR_P2_ODIV: rd_word = {7'h0, odiv2[17:9], 7'h0, odiv2[8:0]};
      `SCL_ADDR_P1_NOW: rd_word = fb1_now[35:4];
      `SCL_ADDR_P2_NOW: rd_word = fb2_now[35:4];
      default: rd_word = 32'h0;
    endcase
  end

  // latched in the setup cycle so the word stands through the access phase
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel && !penable)
      prdata <= rd_word;
  end
endmodule

//--- scl_defines.vh
`ifndef SCL_DEFINES_VH
`define SCL_DEFINES_VH
// apb byte addresses
`define SCL_ADDR_CTRL 12'h000
`define SCL_ADDR_STATUS 12'h004
`define SCL_ADDR_IRQ_STAT 12'h008
`define SCL_ADDR_IRQ_MASK 12'h00c
`define SCL_ADDR_P1_MODE 12'h010
`define SCL_ADDR_P1_FRAC 12'h014
`define SCL_ADDR_P1_RAT 12'h018
`define SCL_ADDR_P1_ODIV 12'h01c
`define SCL_ADDR_P2_MODE 12'h020
`define SCL_ADDR_P2_FRAC 12'h024
`define SCL_ADDR_P2_RAT 12'h028
`define SCL_ADDR_P2_ODIV 12'h02c
`define SCL_ADDR_P1_NOW 12'h030
`define SCL_ADDR_P2_NOW 12'h034
// feedback modes
`define SCL_MODE_INT 2'h0
`define SCL_MODE_FRAC 2'h1
`define SCL_MODE_RAT 2'h2
// field widths
`define SCL_FB_INT_W 8
`define SCL_FB_FRAC_W 28
// output divider range, code 0 means divide by 4.5
`define SCL_ODIV_MIN 9'h004
`define SCL_ODIV_MAX 9'h103
`define SCL_ODIV_HALF 9'h000
// nonvolatile image
`define SCL_OTP_BITS 444
// ctrl bits
`define SCL_CTRL_PLL1_EN 0
`define SCL_CTRL_PLL2_EN 1
`define SCL_CTRL_REF2 2
`define SCL_CTRL_REFCOPY_EN 3
// status bits
`define SCL_ST_LOADED 0
`define SCL_ST_SECURE 1
`define SCL_ST_LOCK1 2
`define SCL_ST_LOCK2 3
`define SCL_ST_SLEW1 4
`define SCL_ST_SLEW2 5
// irq bits
`define SCL_IRQ_LOL1 0
`define SCL_IRQ_LOL2 1
`define SCL_IRQ_LOADED 2
`define SCL_IRQ_DENIED 3
// timing
`define SCL_CLK_HZ 50000000
`define SCL_WAIT_US 4000
`define SCL_SLEW_STEP 16'h0100
`endif

//--- scl_slew.v
`timescale 1ns/1ps
`include "scl_defines.vh"
module scl_slew #(
  parameter W = 36
)
(
  input wire pclk,
  input wire presetn,
  input wire load,
  input wire [W-1:0] target,
  output reg [W-1:0] now,
  output wire busy
);
  // small steps walk toward target; only load jumps straight to it
  localparam [W-1:0] STEP = {{(W-16){1'b0}}, `SCL_SLEW_STEP};
  wire [W-1:0] diff_up = target - now;
  wire [W-1:0] diff_dn = now - target;
  assign busy = (now != target);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      now <= {W{1'b0}};
    else if (load)
      now <= target;
    else if (target > now)
      now <= (diff_up > STEP) ? now + STEP : target;
    else if (target < now)
      now <= (diff_dn > STEP) ? now - STEP : target;
  end
endmodule

//--- scl_props.sv
`timescale 1ns/1ps
module scl_props #(
  parameter WAIT_CYCLES = 8,
  parameter OTP_BITS = 444
)
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire supply_good,
  input wire [OTP_BITS-1:0] otp_image,
  input wire ref_in,
  input wire reference_copy_output,
  input wire pll1_enable,
  input wire [1:0] pll1_mode,
  input wire [35:0] pll1_odiv,
  input wire irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_slverr_map: assert property (psel && penable && paddr > 12'h034 |-> pslverr)
    else $error("unmapped access not flagged");
  chk_ready_now: assert property (psel && penable |-> pready)
    else $error("access not answered");
  chk_refcopy_src: assert property (reference_copy_output |->
    $past(ref_in, 2) || $past(ref_in, 3) || $past(ref_in, 4))
    else $error("reference copy high without reference");
  chk_mode_legal: assert property (pll1_mode != 2'h3)
    else $error("illegal feedback mode");
  chk_odiv_range: assert property (
    pll1_odiv[35:27] <= 9'h103 && pll1_odiv[17:9] <= 9'h103
    && !(pll1_odiv[35:27] inside {9'h1, 9'h2, 9'h3}) && pll1_odiv[26:18] == 9'h0)
    else $error("output divider out of range");
  chk_idle_quiet: assert property ($rose(supply_good) && !pll1_enable |-> (!pll1_enable)[*8])
    else $error("load before wait elapsed");
  chk_otp_load: assert property ($rose(supply_good) && !pll1_enable |->
    ##[1:20] pll1_enable == otp_image[1])
    else $error("image not loaded");
  chk_reset_state: assert property ($rose(presetn) |-> !irq && !pll1_enable)
    else $error("outputs not cleared by reset");
  cover property (psel && penable && pslverr);
  cover property ($rose(irq));
  cover property ($rose(reference_copy_output));
endmodule
bind scl_top scl_props #(.WAIT_CYCLES(WAIT_CYCLES), .OTP_BITS(OTP_BITS)) i_scl_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .supply_good(supply_good), .otp_image(otp_image),
  .ref_in(ref_in), .reference_copy_output(reference_copy_output),
  .pll1_enable(pll1_enable), .pll1_mode(pll1_mode), .pll1_odiv(pll1_odiv), .irq(irq));

//--- scl_host.sv
`timescale 1ns/1ps
module scl_host (
  input wire pclk,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  output reg psel = 1'b0,
  output reg penable = 1'b0,
  output reg pwrite = 1'b0,
  output reg [11:0] paddr = 12'h0,
  output reg [31:0] pwdata = 32'h0,
  output reg [3:0] pstrb = 4'h0
);
  // no calibration registers in this map, so none is addressed
  task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] r, output e);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d; // callers pass reserved bits as zero
      pstrb <= 4'hf;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a; // released lines must not keep the last value
      pwdata <= ~d;
    end
  endtask
endmodule

//--- synth_config_loader_tb.sv
`timescale 1ns/1ps
module synth_config_loader_tb;
  localparam [443:0] IMG = (444'h122345000 << 9) | 444'hd2;
  reg pclk, presetn, supply_good, lock1_in, lock2_in, er;
  reg [3:0] rc;
  reg [443:0] otp;
  reg [31:0] rd;
  reg [75:0] rows [0:7];
  integer failures, total_checks, i, n;
  wire psel, penable, pwrite, pready, pslverr, irq, refcopy;
  wire en1, en2, rsel;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [3:0] pstrb;
  wire [1:0] m1, m2;
  wire [35:0] fb1, fb2, od1, od2;
  wire [63:0] rat1, rat2;
  wire ref_in = rc[3];
  scl_host i_scl_host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
  scl_top #(.WAIT_CYCLES(8)) i_scl_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply_good(supply_good),
    .otp_image(otp), .lock1_in(lock1_in), .lock2_in(lock2_in), .ref_in(ref_in),
    .reference_copy_output(refcopy), .pll1_enable(en1), .pll2_enable(en2), .ref_select(rsel),
    .pll1_mode(m1), .pll2_mode(m2), .pll1_fb(fb1), .pll2_fb(fb2), .pll1_ratio(rat1),
    .pll2_ratio(rat2), .pll1_odiv(od1), .pll2_odiv(od2), .irq(irq));
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) rc <= rc + 4'h1;
  task chk(input string nm, input [63:0] got, input [63:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
        failures = failures + 1;
        $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    i_scl_host.xfer(1'b1, a, d, rd, er);
  endtask
  task rdc(input [11:0] a, input [31:0] x, input string nm);
    begin
      i_scl_host.xfer(1'b0, a, 32'h0, rd, er);
      chk(nm, rd, x);
    end
  endtask
  task boot(input [443:0] img);
    begin
      otp <= img;
      presetn <= 1'b0;
      supply_good <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial
  begin
    #1000000;
    failures = failures + 1;
    stop_test;
  end
  initial
  begin
    failures = 0;
    total_checks = 0;
    rc = 4'h0;
    lock1_in = 1'b1;
    lock2_in = 1'b1;
    presetn = 1'b0;
    supply_good = 1'b0;
    otp = IMG;
    rows[0] = {12'h000, 32'hf, 32'hf};
    rows[1] = {12'h010, 32'h1, 32'h1};
    rows[2] = {12'h020, 32'h2, 32'h2};
    rows[3] = {12'h01c, 32'h40103, 32'h40103};
    rows[4] = {12'h02c, 32'h0, 32'h0};
    rows[5] = {12'h00c, 32'h8, 32'h8};
    rows[6] = {12'h020, 32'h3, 32'h0};
    rows[7] = {12'h02c, 32'h01ff0002, 32'h01030004};
    boot(IMG);
    wr(12'h000, 32'h5); // too early on purpose: must be dropped
    supply_good <= 1'b1;
    repeat (16) @(posedge pclk);
    rdc(12'h000, 32'h9, "ctrl");
    rdc(12'h004, 32'hd, "status");
    rdc(12'h008, 32'hc, "irq_stat");
    chk("mode1", m1, 2'h2);
    chk("mode2", m2, 2'h1);
    chk("ctrl pins", {rsel, en2, en1}, 3'h1);
    chk("fb2", fb2, 36'h0);
    $display("load test done");
    wr(12'h014, 32'h12345678);
    n = 0;
    while (fb1 !== 36'h122345678 && n < 50) @(posedge pclk) n = n + 1;
    chk("fb", fb1, 36'h122345678);
    chk("fb steps", n > 2, 1);
    rdc(12'h014, 32'h12345678, "frac");
    rdc(12'h030, 32'h12234567, "fb now");
    wr(12'h018, 32'h7);
    wr(12'h018, 32'h3);
    wr(12'h028, 32'h9);
    wr(12'h028, 32'h5);
    @(posedge pclk);
    chk("ratio", rat1, {32'h7, 32'h3});
    chk("ratio2", rat2, {32'h9, 32'h5});
    for (i = 0; i < 8; i = i + 1)
    begin
      wr(rows[i][75:64], rows[i][63:32]);
      rdc(rows[i][75:64], rows[i][31:0], "row");
    end
    chk("mode1 frac", m1, 2'h1);
    chk("mode2 fix", m2, 2'h0);
    chk("ctrl pins on", {rsel, en2, en1}, 3'h7);
    chk("odiv1", od1, {9'h004, 9'h0, 9'h103, 9'h0});
    chk("odiv2", od2, {9'h103, 9'h0, 9'h004, 9'h0});
    chk("irq", irq, 1'b1);
    wr(12'h008, 32'h8);
    @(posedge pclk);
    chk("irq clr", irq, 1'b0);
    lock1_in <= 1'b0;
    lock2_in <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("irq masked", irq, 1'b0);
    wr(12'h00c, 32'h1);
    @(posedge pclk);
    chk("irq lol", irq, 1'b1);
    rdc(12'h008, 32'h7, "lol stat");
    wr(12'h008, 32'h7);
    @(posedge pclk);
    chk("irq clr2", irq, 1'b0);
    $display("register test done");
    n = 0;
    repeat (40) @(posedge pclk) n = n + refcopy;
    chk("refcopy on", n > 0, 1);
    wr(12'h000, 32'h7);
    repeat (6) @(posedge pclk);
    n = 0;
    repeat (40) @(posedge pclk) n = n + refcopy;
    chk("refcopy off", n, 0);
    i_scl_host.xfer(1'b0, 12'h100, 32'h0, rd, er);
    chk("slverr", er, 1'b1);
    $display("output test done");
    lock1_in <= 1'b1;
    lock2_in <= 1'b1;
    boot(IMG | 444'h1);
    supply_good <= 1'b1;
    repeat (16) @(posedge pclk);
    wr(12'h000, 32'h0);
    rdc(12'h000, 32'h9, "secure ctrl");
    rdc(12'h004, 32'hf, "secure status");
    rdc(12'h008, 32'hc, "denied");
    $display("secure test done");
    stop_test;
  end
endmodule
